// ---- hw/lsic_sync_irq.sv ----
// sync irq control register bank with axi4-lite slave, status flags and interrupt
module lsic_sync_irq (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic bus_rx,
  input wire logic brk_match,
  output logic irq
);
  lsic_pkg::lsic_events_t ev;
  logic [15:0] ctrl_reg;
  logic [lsic_pkg::STAT_W-1:0] stat_reg, stat_next;
  logic [lsic_pkg::STAT_W-1:0] pend_reg, pend_next;
  logic [lsic_pkg::STAT_W-1:0] mask_reg;
  lsic_pkg::lsic_mode_t mode_reg;
  logic [31:0] awaddr_reg, wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_full_reg, w_full_reg;
  logic do_write, rd_hs, rd_stat, rise_irq_en, brk_irq_en;
  logic [lsic_pkg::STAT_W-1:0] ev_vec, pend_set, w1c;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    hit = (a[31:2] == off[31:2]);
  endfunction

  function automatic logic mapped(input logic [31:0] a);
    mapped = hit(a, lsic_pkg::SYNC_STATUS_FLAGS_OFF) | hit(a, lsic_pkg::SYNC_IRQ_CONTROL_OFF)
           | hit(a, lsic_pkg::IRQ_PENDING_OFF) | hit(a, lsic_pkg::IRQ_MASK_OFF)
           | hit(a, lsic_pkg::MODE_SELECT_OFF);
  endfunction

  lsic_event_det u_det (
    .clk(clk),
    .reset_n(reset_n),
    .bus_rx(bus_rx),
    .brk_match(brk_match),
    .events(ev)
  );

  // write path: address and data latched independently, committed together
  assign do_write = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  assign rd_hs = s_axi_arvalid & s_axi_arready;
  assign rd_stat = rd_hs & hit(s_axi_araddr, lsic_pkg::SYNC_STATUS_FLAGS_OFF);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= lsic_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_reg <= s_axi_awaddr;
        aw_full_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        w_full_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awaddr_reg) ? lsic_pkg::RESP_OKAY : lsic_pkg::RESP_SLVERR;
      end
      // reopen only after the response is taken: one write in flight
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // control register, reserved top bits never stored
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_reg <= lsic_pkg::CTRL_RESET;
    end else if (do_write && hit(awaddr_reg, lsic_pkg::SYNC_IRQ_CONTROL_OFF)) begin
      if (wstrb_reg[0]) begin
        ctrl_reg[7:0] <= wdata_reg[7:0];
      end
      if (wstrb_reg[1]) begin
        ctrl_reg[lsic_pkg::CTRL_USED_MSB:8] <= wdata_reg[lsic_pkg::CTRL_USED_MSB:8];
      end
    end
  end

  // mask and mode registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mask_reg <= lsic_pkg::MASK_RESET;
      mode_reg <= lsic_pkg::LSIC_MODE_LIN;
    end else if (do_write && wstrb_reg[0]) begin
      if (hit(awaddr_reg, lsic_pkg::IRQ_MASK_OFF)) begin
        mask_reg <= wdata_reg[lsic_pkg::STAT_W-1:0];
      end
      if (hit(awaddr_reg, lsic_pkg::MODE_SELECT_OFF)) begin
        mode_reg <= lsic_pkg::lsic_mode_t'(wdata_reg[0]);
      end
    end
  end

  // bit 12 flips meaning with the mode; bit 11 is a disable
  assign rise_irq_en = (mode_reg == lsic_pkg::LSIC_MODE_ALT)
                     ? ~ctrl_reg[lsic_pkg::CTRL_RISE_IRQ_BIT]
                     : ctrl_reg[lsic_pkg::CTRL_RISE_IRQ_BIT];
  assign brk_irq_en = ~ctrl_reg[lsic_pkg::CTRL_BRK_IRQ_DIS_BIT];

  // status flags: set by events, the rise flag only in alternate mode, cleared by a status read, set wins
  always_comb begin
    ev_vec = '0;
    ev_vec[lsic_pkg::STAT_RISE_BIT] = ev.rise & (mode_reg == lsic_pkg::LSIC_MODE_ALT);
    ev_vec[lsic_pkg::STAT_BRK_BIT] = ev.brk;
    stat_next = (rd_stat ? '0 : stat_reg) | ev_vec;
  end

  // pending bits feed the irq; w1c, set wins over clear
  always_comb begin
    pend_set = '0;
    pend_set[lsic_pkg::STAT_RISE_BIT] = ev.rise & rise_irq_en;
    pend_set[lsic_pkg::STAT_BRK_BIT] = ev.brk & brk_irq_en;
    w1c = (do_write && wstrb_reg[0] && hit(awaddr_reg, lsic_pkg::IRQ_PENDING_OFF))
        ? wdata_reg[lsic_pkg::STAT_W-1:0] : '0;
    pend_next = (pend_reg & ~w1c) | pend_set;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stat_reg <= lsic_pkg::STAT_RESET;
      pend_reg <= lsic_pkg::STAT_RESET;
      irq <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      pend_reg <= pend_next;
      irq <= |(pend_next & mask_reg); // registered so the pin is glitch free
    end
  end

  // read path: data one cycle after the address is taken
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= lsic_pkg::RESP_OKAY;
    end else begin
      if (rd_hs) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(s_axi_araddr) ? lsic_pkg::RESP_OKAY : lsic_pkg::RESP_SLVERR;
        s_axi_rdata <= '0;
        if (hit(s_axi_araddr, lsic_pkg::SYNC_STATUS_FLAGS_OFF)) begin
          s_axi_rdata[lsic_pkg::STAT_W-1:0] <= stat_reg;
        end
        if (hit(s_axi_araddr, lsic_pkg::SYNC_IRQ_CONTROL_OFF)) begin
          s_axi_rdata[15:0] <= ctrl_reg;
        end
        if (hit(s_axi_araddr, lsic_pkg::IRQ_PENDING_OFF)) begin
          s_axi_rdata[lsic_pkg::STAT_W-1:0] <= pend_reg;
        end
        if (hit(s_axi_araddr, lsic_pkg::IRQ_MASK_OFF)) begin
          s_axi_rdata[lsic_pkg::STAT_W-1:0] <= mask_reg;
        end
        if (hit(s_axi_araddr, lsic_pkg::MODE_SELECT_OFF)) begin
          s_axi_rdata[0] <= mode_reg;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // control at zero and nothing pending on the bus or the pin once reset lets go
  property p_ctrl_reset;
    $rose(reset_n) |-> ctrl_reg == lsic_pkg::CTRL_RESET && !irq
                       && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not zero after reset");

  // a pending bit already set hides the gate, so only a clear bit is judged
  property p_alt_rise;
    ev.rise && mode_reg == lsic_pkg::LSIC_MODE_ALT && !pend_reg[lsic_pkg::STAT_RISE_BIT]
      |=> pend_reg[lsic_pkg::STAT_RISE_BIT]
          == !$past(ctrl_reg[lsic_pkg::CTRL_RISE_IRQ_BIT]);
  endproperty
  a_alt_rise: assert property (p_alt_rise) else $error("alt mode rise irq gating wrong");

  property p_lin_rise;
    ev.rise && mode_reg == lsic_pkg::LSIC_MODE_LIN && !pend_reg[lsic_pkg::STAT_RISE_BIT]
      |=> pend_reg[lsic_pkg::STAT_RISE_BIT]
          == $past(ctrl_reg[lsic_pkg::CTRL_RISE_IRQ_BIT]);
  endproperty
  a_lin_rise: assert property (p_lin_rise) else $error("lin mode rise irq gating wrong");

  property p_brk_gate;
    ev.brk && !pend_reg[lsic_pkg::STAT_BRK_BIT]
      |=> pend_reg[lsic_pkg::STAT_BRK_BIT] == !$past(ctrl_reg[lsic_pkg::CTRL_BRK_IRQ_DIS_BIT]);
  endproperty
  a_brk_gate: assert property (p_brk_gate) else $error("break irq gating wrong");

  property p_rise_flag;
    ev.rise && mode_reg == lsic_pkg::LSIC_MODE_ALT |=> stat_reg[lsic_pkg::STAT_RISE_BIT];
  endproperty
  a_rise_flag: assert property (p_rise_flag) else $error("rise flag not set");

  property p_brk_flag;
    ev.brk |=> stat_reg[lsic_pkg::STAT_BRK_BIT];
  endproperty
  a_brk_flag: assert property (p_brk_flag) else $error("break flag not set");

  // irq lags the mask by one edge, hence the past mask
  property p_masked_flag;
    ev.brk && ctrl_reg[lsic_pkg::CTRL_BRK_IRQ_DIS_BIT] && !pend_reg[lsic_pkg::STAT_BRK_BIT]
      |=> stat_reg[lsic_pkg::STAT_BRK_BIT] && !pend_reg[lsic_pkg::STAT_BRK_BIT]
          && (irq == |(pend_reg & $past(mask_reg)));
  endproperty
  a_masked_flag: assert property (p_masked_flag) else $error("masked event lost its flag");

  // data stands the edge after the address is taken, flags already gone
  property p_read_clear;
    rd_stat && !ev.brk && !ev.rise |=> stat_reg == '0 && s_axi_rvalid;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("status read did not clear");

  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_rise_irq: cover property (ev.rise ##1 irq);
  c_read_stat: cover property (rd_stat && stat_reg[0]);
endmodule // lsic_sync_irq

// ---- pkg/lsic_pkg.sv ----
// package: register map, field positions and shared types of the sync irq control block
package lsic_pkg;
  // byte addresses of the registers
  localparam logic [31:0] SYNC_STATUS_FLAGS_OFF = 32'hffff_0780;
  localparam logic [31:0] SYNC_IRQ_CONTROL_OFF = 32'hffff_0784;
  localparam logic [31:0] IRQ_PENDING_OFF = 32'hffff_0790;
  localparam logic [31:0] IRQ_MASK_OFF = 32'hffff_0794;
  localparam logic [31:0] MODE_SELECT_OFF = 32'hffff_0798;
  // field positions
  localparam int CTRL_RISE_IRQ_BIT = 12;
  localparam int CTRL_BRK_IRQ_DIS_BIT = 11;
  localparam int CTRL_USED_MSB = 12;
  localparam int STAT_RISE_BIT = 6;
  localparam int STAT_BRK_BIT = 0;
  localparam int STAT_W = 7;
  // reset values
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [STAT_W-1:0] STAT_RESET = 7'h00;
  localparam logic [STAT_W-1:0] MASK_RESET = 7'h00;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {
    LSIC_MODE_LIN = 1'b0,
    LSIC_MODE_ALT = 1'b1
  } lsic_mode_t;

  // one-cycle bus events handed from the detector to the register bank
  typedef struct packed {
    logic rise;
    logic brk;
  } lsic_events_t;
endpackage

// ---- hw/lsic_event_det.sv ----
// edge detector: rising edge on the bus line and break compare arrival
module lsic_event_det (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic bus_rx,
  input wire logic brk_match,
  output lsic_pkg::lsic_events_t events
);
  logic rx_prev_reg;
  logic brk_prev_reg;

  // idle lin line is high, so prev starts high to avoid a fake edge
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rx_prev_reg <= 1'b1;
      brk_prev_reg <= 1'b0;
      events <= '0;
    end else begin
      rx_prev_reg <= bus_rx;
      brk_prev_reg <= brk_match;
      events.rise <= bus_rx & ~rx_prev_reg;
      events.brk <= brk_match & ~brk_prev_reg; // match is a level, fire once
    end
  end
endmodule // lsic_event_det

// ---- verif/lsic_bus_model.sv ----
// far-side bus node: drives the receive line and the break compare level
module lsic_bus_model (
  input wire logic clk,
  output logic bus_rx,
  output logic brk_match
);
  timeunit 1ns;
  timeprecision 100ps;
  // recessive line and no break until a frame asks for one
  initial begin
    bus_rx = 1'b1;
    brk_match = 1'b0;
  end
  // dominant pulse then release, the release is the rising edge
  task automatic rise;
    bus_rx <= 1'b0;
    repeat (3) @(posedge clk);
    bus_rx <= 1'b1;
  endtask
  // break timer reaches its compare value for two cycles
  task automatic brk;
    brk_match <= 1'b1;
    repeat (2) @(posedge clk);
    brk_match <= 1'b0;
  endtask
endmodule // lsic_bus_model

// ---- verif/lsic_sync_irq_tb.sv ----
// testbench: register access, event flags and interrupt of the sync irq control block
module lsic_sync_irq_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] ST = lsic_pkg::SYNC_STATUS_FLAGS_OFF;
  localparam logic [31:0] CT = lsic_pkg::SYNC_IRQ_CONTROL_OFF;
  localparam logic [31:0] PD = lsic_pkg::IRQ_PENDING_OFF;
  localparam logic [31:0] MK = lsic_pkg::IRQ_MASK_OFF;
  localparam logic [31:0] MD = lsic_pkg::MODE_SELECT_OFF;
  localparam logic [1:0] OK = lsic_pkg::RESP_OKAY;
  logic clk, reset_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, bus_rx, brk_match;
  logic [31:0] awaddr, wdata, araddr, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [33:0] qw[$], qr[$];
  logic [31:0] regs [5] = '{ST, CT, PD, MK, MD};
  int fails, total_checks;

  lsic_sync_irq lsic_sync_irq_i (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bus_rx(bus_rx),
    .brk_match(brk_match), .irq(irq));
  lsic_bus_model lsic_bus_model_i (.clk(clk), .bus_rx(bus_rx), .brk_match(brk_match));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    int n = 0;
    qw.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    if (n >= 50) begin fails++; complete_run(); end
    @(posedge clk); // idle edge: the next call must not re-raise bready in this step
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    int n = 0;
    qr.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    if (n >= 50) begin fails++; complete_run(); end
    @(posedge clk); // idle edge: the next call must not re-raise rready in this step
  endtask

  // irq is registered, so give the event path four edges to settle
  task automatic sense(input logic e);
    repeat (4) @(posedge clk);
    check({33'h0, irq}, {33'h0, e});
  endtask

  // response watcher: each handshake retires the oldest expectation
  always @(posedge clk) begin
    if (bvalid && bready && qw.size() > 0) check({bresp, 32'h0}, qw.pop_front());
    if (rvalid && rready && qr.size() > 0) check({rresp, rdata}, qr.pop_front());
  end

  initial begin
    {reset_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hf;
    fails = 0;
    total_checks = 0;
    v = $urandom(32'he6079f1e);
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    foreach (regs[i]) rd(regs[i], 32'h0, OK);
    $display("test 1 finished");
    v = $urandom;
    wr(CT, v & 32'h0000_1fff, OK);
    rd(CT, {19'h0, v[12:0]}, OK);
    wr(32'hffff_07a0, 32'h0, lsic_pkg::RESP_SLVERR);
    rd(CT, {19'h0, v[12:0]}, OK);
    // mid-run reset must put the control word and mode back to zero
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(CT, 32'h0, OK);
    rd(MD, 32'h0, OK);
    $display("test 2 finished");
    // alternate bus mode, rising edge interrupt let through with bit 12 clear, blocked with it set
    wr(MK, 32'h41, OK);
    wr(MD, 32'h1, OK);
    wr(CT, 32'h0, OK);
    lsic_bus_model_i.rise();
    sense(1'b1);
    rd(ST, 32'h40, OK);
    rd(ST, 32'h0, OK);
    wr(PD, 32'h7f, OK);
    sense(1'b0);
    wr(CT, 32'h1000, OK);
    lsic_bus_model_i.rise();
    sense(1'b0);
    rd(ST, 32'h40, OK);
    $display("test 3 finished");
    // lin mode: bit 12 polarity turns round
    wr(MD, 32'h0, OK);
    lsic_bus_model_i.rise();
    sense(1'b1);
    rd(ST, 32'h0, OK);
    wr(PD, 32'h7f, OK);
    wr(CT, 32'h0, OK);
    lsic_bus_model_i.rise();
    sense(1'b0);
    $display("test 4 finished");
    // break compare: enabled, disabled, then masked
    lsic_bus_model_i.brk();
    sense(1'b1);
    rd(ST, 32'h1, OK);
    rd(PD, 32'h1, OK);
    wr(PD, 32'h7f, OK);
    wr(CT, 32'h800, OK);
    lsic_bus_model_i.brk();
    sense(1'b0);
    rd(ST, 32'h1, OK);
    wr(CT, 32'h0, OK);
    wr(MK, 32'h0, OK);
    lsic_bus_model_i.brk();
    sense(1'b0);
    rd(PD, 32'h1, OK);
    $display("test 5 finished");
    repeat (2) @(posedge clk);
    complete_run();
  end
endmodule // lsic_sync_irq_tb
